// ===== hw/ipr_bank.sv
// Purpose: exception return, interrupt clear, serial receive, flush,
//   mode and arithmetic trap summary registers
// Assumes: register moves arrive one at a time on the ipr_* port
// Notes: read data and every output are registered
`timescale 1ns/10ps
`default_nettype none
`include "ipr_cfg.svh"
module ipr_bank
  import ipr_pkg::*;
#(
  parameter int MASK_W = `MASK_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register move port
  input wire logic ipr_wr,
  input wire logic ipr_rd,
  input wire ipr_sel_t ipr_sel,
  input wire logic [63:0] ipr_wdata,
  output logic [63:0] ipr_rdata,
  output logic ipr_rd_valid,
  // exception entry
  input wire logic exc_valid,
  input wire exc_kind_t exc_kind,
  input wire logic [63:0] exc_pc,
  input wire logic exc_in_privileged_mode,
  input wire logic exc_pc_correct,
  // return from exception
  input wire logic return_from_exception,
  output logic rei_jump,
  output logic [63:0] rei_target,
  output logic rei_privileged_code_mode,
  output logic rei_translate_en,
  // arithmetic traps
  input wire logic trap_valid,
  input wire logic [`SUM_FLAG_W-1:0] trap_flags,
  input wire logic trap_sw_completion,
  input wire logic trap_dest_float,
  input wire logic [4:0] trap_dest_reg,
  // serial line
  input wire logic icache_loaded,
  input wire logic boot_rom_data_pin,
  input wire logic serial_interrupt_enable,
  output logic serial_interrupt_request,
  output logic serial_irq,
  // interrupt request clears
  output logic event_counter0_clear,
  output logic event_counter1_clear,
  output logic correctable_read_error_clear,
  // translation buffer flushes
  output logic itlb_invalidate_all,
  output logic itlb_invalidate_nonglobal
);

  logic [63:0] exception_return_address_r;
  logic [1:0] current_mode_r;
  logic [MASK_W-1:0] dest_mask_r;
  logic [1:0] shift_cnt_r;
  logic swc_ok_r;
  logic [`SUM_FLAG_W-1:0] sum_flags;
  logic software_completion_flag;
  logic serial_line_prev_r;
  logic serial_receive_bit;
  logic serial_edge;
  logic serial_clr;
  logic sum_wr;
  logic sum_rd;
  logic wr_return_addr;
  logic wr_clear;
  logic [63:0] exc_save;
  logic [MASK_W-1:0] dest_onehot;
  logic [5:0] dest_idx;
  logic dest_mask_window;

  assign sum_wr = ipr_wr && (ipr_sel == sel_arithmetic_trap_summary);
  assign sum_rd = ipr_rd && (ipr_sel == sel_arithmetic_trap_summary);
  assign wr_return_addr = ipr_wr &&
                          (ipr_sel == sel_exception_return_address);
  assign wr_clear = ipr_wr && (ipr_sel == sel_interrupt_request_clear);

  // return address composition on entry
  always_comb begin
    exc_save = {exc_pc[63:2], 1'b0, exc_in_privileged_mode};
    if (exc_kind == exc_privileged_call) begin
      exc_save = exc_pc + `PC_STEP;
      exc_save[`EXCEPTION_RETURN_ADDRESS_FIX_BIT] = 1'b0;
      exc_save[`EXCEPTION_RETURN_ADDRESS_MODE_BIT] = exc_in_privileged_mode;
    end else if (exc_kind == exc_arith_trap ||
                 exc_kind == exc_machine_check) begin
      exc_save[`EXCEPTION_RETURN_ADDRESS_FIX_BIT] = exc_pc_correct;
    end
  end

  // hardware entry beats a software write in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exception_return_address_r <= 64'h0;
    end else if (exc_valid) begin
      exception_return_address_r <= exc_save;
    end else if (wr_return_addr) begin
      exception_return_address_r <= ipr_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rei_jump <= 1'b0;
      rei_target <= 64'h0;
      rei_privileged_code_mode <= 1'b0;
      rei_translate_en <= 1'b0;
    end else begin
      rei_jump <= return_from_exception;
      if (return_from_exception) begin
        rei_target <= {exception_return_address_r[63:2], 2'b00};
        rei_privileged_code_mode <=
          exception_return_address_r[`EXCEPTION_RETURN_ADDRESS_MODE_BIT];
        rei_translate_en <=
          !exception_return_address_r[`EXCEPTION_RETURN_ADDRESS_MODE_BIT];
      end
    end
  end

  // current mode, the only stored bits of the mode register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      current_mode_r <= 2'b00;
    end else if (ipr_wr && ipr_sel == sel_processor_mode_status) begin
      current_mode_r <= ipr_wdata[`MODE_HI_BIT:`MODE_LO_BIT];
    end
  end

  // serial line: pins are synchronous, so no synchroniser here
  assign serial_receive_bit = icache_loaded && boot_rom_data_pin;
  assign serial_edge = icache_loaded &&
                       (boot_rom_data_pin != serial_line_prev_r);
  assign serial_clr = wr_clear && !ipr_wdata[`CLR_SLC_BIT];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_line_prev_r <= 1'b0;
    end else begin
      // tracked before the load too, so the load itself is no edge
      serial_line_prev_r <= boot_rom_data_pin;
    end
  end

  sticky_flag u_serial_req (
    .clk(clk),
    .arst_n(arst_n),
    .set(serial_edge),
    .clr(serial_clr),
    .q(serial_interrupt_request)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_irq <= 1'b0;
    end else begin
      serial_irq <= (serial_edge || (serial_interrupt_request &&
                     !serial_clr)) && serial_interrupt_enable;
    end
  end

  // clear pulses for requests kept outside; ones change nothing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      event_counter0_clear <= 1'b0;
      event_counter1_clear <= 1'b0;
      correctable_read_error_clear <= 1'b0;
    end else begin
      event_counter0_clear <= wr_clear && !ipr_wdata[`CLR_PC0_BIT];
      event_counter1_clear <= wr_clear && !ipr_wdata[`CLR_PC1_BIT];
      correctable_read_error_clear <=
        wr_clear && !ipr_wdata[`CLR_CRD_BIT];
    end
  end

  // any data value triggers a flush; privilege is not checked
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      itlb_invalidate_all <= 1'b0;
      itlb_invalidate_nonglobal <= 1'b0;
    end else begin
      itlb_invalidate_all <= ipr_wr &&
        (ipr_sel == sel_itlb_flush_all ||
         ipr_sel == sel_itlb_flush_single);
      itlb_invalidate_nonglobal <= ipr_wr &&
        (ipr_sel == sel_itlb_flush_nonglobal);
    end
  end

  // summary flags, one sticky cell each
  genvar gi;
  generate
    for (gi = 0; gi < `SUM_FLAG_W; gi++) begin : g_sum
      sticky_flag u_flag (
        .clk(clk),
        .arst_n(arst_n),
        .set(trap_valid && trap_flags[gi]),
        .clr(sum_wr),
        .q(sum_flags[gi])
      );
    end
  endgenerate

  // completion flag: trap in the write cycle still counts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      swc_ok_r <= 1'b1;
    end else if (trap_valid) begin
      swc_ok_r <= trap_sw_completion && (swc_ok_r || sum_wr);
    end else if (sum_wr) begin
      swc_ok_r <= 1'b1;
    end
  end

  sticky_flag u_swc (
    .clk(clk),
    .arst_n(arst_n),
    .set(trap_valid && trap_sw_completion && (swc_ok_r || sum_wr)),
    .clr(sum_wr || (trap_valid && !trap_sw_completion)),
    .q(software_completion_flag)
  );

  // destination mask: bit 63 is F31, bit 32 F0, bit 31 I31, bit 0 I0
  assign dest_idx = {trap_dest_float, trap_dest_reg};
  assign dest_onehot = trap_valid ?
                       (MASK_W'(1) << dest_idx) : '0;
  assign dest_mask_window = dest_mask_r[MASK_W-1];

  // a read during a pending shift sees the same bit again
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_cnt_r <= 2'd0;
    end else if (shift_cnt_r != 2'd0) begin
      shift_cnt_r <= shift_cnt_r - 2'd1;
    end else if (sum_rd) begin
      shift_cnt_r <= `MASK_SHIFT_DELAY;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dest_mask_r <= '0;
    end else if (shift_cnt_r == 2'd1) begin
      dest_mask_r <= {dest_mask_r[MASK_W-2:0], 1'b0} | dest_onehot;
    end else begin
      dest_mask_r <= dest_mask_r | dest_onehot;
    end
  end

  // read data, one cycle after the request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ipr_rdata <= 64'h0;
      ipr_rd_valid <= 1'b0;
    end else begin
      ipr_rd_valid <= ipr_rd;
      if (ipr_rd) begin
        ipr_rdata <= 64'h0;
        if (ipr_sel == sel_exception_return_address) begin
          ipr_rdata <= exception_return_address_r;
        end else if (ipr_sel == sel_serial_receive_line) begin
          ipr_rdata <= {63'h0, serial_receive_bit};
        end else if (ipr_sel == sel_processor_mode_status) begin
          ipr_rdata[`MODE_HI_BIT:`MODE_LO_BIT] <= current_mode_r;
        end else if (ipr_sel == sel_arithmetic_trap_summary) begin
          ipr_rdata[`SUM_MSK_BIT] <= dest_mask_window;
          ipr_rdata[`SUM_SWC_BIT] <= software_completion_flag;
          ipr_rdata[`SUM_FLAG_LO_BIT +: `SUM_FLAG_W] <= sum_flags;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_CALL_NEXT: assert property (
    exc_valid && exc_kind == exc_privileged_call |=>
      exception_return_address_r[63:2] == ($past(exc_pc[63:2]) + 62'h1))
    else $error("call entry did not save the following address");
  AST_FIX_BIT_OTHER: assert property (
    exc_valid && (exc_kind == exc_other ||
                  exc_kind == exc_privileged_call) |=>
      !exception_return_address_r[`EXCEPTION_RETURN_ADDRESS_FIX_BIT])
    else $error("bit 1 set on an ordinary entry");
  AST_FIX_BIT_TRAP: assert property (
    exc_valid && (exc_kind == exc_arith_trap ||
                  exc_kind == exc_machine_check) |=>
      exception_return_address_r[`EXCEPTION_RETURN_ADDRESS_FIX_BIT] ==
      $past(exc_pc_correct))
    else $error("bit 1 does not show the correction on trap entry");
  AST_REI_TARGET: assert property (
    return_from_exception && !exception_return_address_r[0] |=>
      rei_jump && rei_translate_en && !rei_privileged_code_mode)
    else $error("return to native mode without translation");
  AST_MODE_RAZ: assert property (
    ipr_rd && ipr_sel == sel_processor_mode_status |=>
      ipr_rd_valid && ipr_rdata[63:5] == 59'h0 && ipr_rdata[2:0] == 3'h0)
    else $error("mode register read shows ignored bits");
  AST_SUM_WRITE: assert property (
    sum_wr && !trap_valid && shift_cnt_r != 2'd1 |=>
      sum_flags == '0 && !software_completion_flag &&
      dest_mask_r == $past(dest_mask_r))
    else $error("summary write did not clear flags or touched mask");
  AST_SHIFT_TIMING: assert property (
    sum_rd && shift_cnt_r == 2'd0 |=>
      shift_cnt_r == 2'd3 ##1 shift_cnt_r == 2'd2 ##1
      shift_cnt_r == 2'd1 ##1 shift_cnt_r == 2'd0)
    else $error("mask shift countdown is not three cycles");
  AST_SHIFT_CLEAR: assert property (
    shift_cnt_r == 2'd1 && !trap_valid |=>
      dest_mask_r == {$past(dest_mask_r[MASK_W-2:0]), 1'b0})
    else $error("mask did not clear and advance");
  AST_SERIAL_SET: assert property (
    serial_edge |=> serial_interrupt_request)
    else $error("receive transition did not raise request");
  AST_SERIAL_GATE: assert property (
    !serial_interrupt_enable |=> !serial_irq)
    else $error("serial interrupt passed while disabled");
  AST_CLEAR_ONE_KEEPS: assert property (
    wr_clear && ipr_wdata[`CLR_SLC_BIT] && !serial_edge |=>
      serial_interrupt_request == $past(serial_interrupt_request))
    else $error("a one in the clear bit changed the request");
  AST_FLUSH_ALL: assert property (
    ipr_wr && ipr_sel == sel_itlb_flush_single |=>
      itlb_invalidate_all && !itlb_invalidate_nonglobal)
    else $error("single flush did not invalidate all entries");
  AST_FLUSH_NONGLOBAL: assert property (
    ipr_wr && ipr_sel == sel_itlb_flush_nonglobal |=>
      itlb_invalidate_nonglobal && !itlb_invalidate_all)
    else $error("non-global flush gave the wrong invalidate pulse");
  AST_CLEAR_PULSE: assert property (
    wr_clear && !ipr_wdata[`CLR_CRD_BIT] |=>
      correctable_read_error_clear)
    else $error("zero in the read error bit gave no clear pulse");
  AST_SWC_PLAIN_CLEARS: assert property (
    trap_valid && !trap_sw_completion |=> !software_completion_flag)
    else $error("unqualified trap left the completion flag set");
  AST_SUM_WINDOW: assert property (
    sum_rd |=>
      ipr_rdata[`SUM_MSK_BIT] == $past(dest_mask_r[MASK_W-1]))
    else $error("summary read did not show the top mask bit");

  COV_TRAP_ENTRY: cover property (
    exc_valid && exc_kind == exc_arith_trap ##1 return_from_exception);
  COV_MASK_READ: cover property (
    trap_valid ##1 sum_rd ##3 sum_rd);
  COV_SERIAL: cover property (serial_edge ##1 wr_clear);
  COV_FLUSH: cover property (itlb_invalidate_nonglobal);

endmodule
`default_nettype wire

// ===== hw/ipr_cfg.svh
// Purpose: constants for the exception and translation-flush register group
// Assumes: one core clock, registers reached by move-to/from instructions
// Notes: bit positions and counts used by ipr_bank and its bench
//
// Notes on behaviour
// - exception entry saves address of the instruction that did not complete
// - return address register is also read and written by software
// - return from exception jumps to the saved return address
// - return address bit 0 selects privileged mode; clear means native, mapped
// - privileged call saves address of the following instruction
// - trap or machine check: bit 1 zero means address four too large
// - all other entries except reset save bit 1 as zero
// - clear register is write-only; zero in a bit clears that request
// - after cache load, receive bit follows the boot memory data pin
// - any receive line transition sets the serial interrupt request; here only pin transitions after cache load do, not the load itself
// - serial interrupt suppressed while its enable bit is clear
// - flush-all or flush-single write invalidates all eight entries, resets pointer
// - non-global flush write invalidates entries with match flag zero
// - mode register holds only current-mode bits; others ignored, read zero
// - arithmetic trap sets its summary bit until summary register written
// - trap also sets destination bit in 64-bit float-then-integer mask
// - each summary read shows one mask bit, clears it, advances; here a read while a shift is pending shows the same bit and starts no shift
// - summary write clears bits 8 to 2, leaves mask unchanged
// - mask clears and shifts three cycles after a read
// - completion flag set by qualified traps, cleared by others or writes; here set only if no unqualified trap came since the last write
`ifndef IPR_CFG_SVH
`define IPR_CFG_SVH

`define IPR_W 64
`define PC_STEP 64'h0000_0000_0000_0004
`define EXCEPTION_RETURN_ADDRESS_MODE_BIT 0
`define EXCEPTION_RETURN_ADDRESS_FIX_BIT 1
`define CLR_CRD_BIT 3
`define CLR_PC0_BIT 8
`define CLR_PC1_BIT 15
`define CLR_SLC_BIT 32
`define MODE_LO_BIT 3
`define MODE_HI_BIT 4
`define SUM_SWC_BIT 2
`define SUM_FLAG_LO_BIT 3
`define SUM_FLAG_W 6
`define SUM_MSK_BIT 33
`define MASK_W 64
`define MASK_SHIFT_DELAY 2'd3
`define ITLB_ENTRIES 8

`endif

// ===== hw/ipr_pkg.sv
// Purpose: types shared by the register group
// Assumes: nothing beyond the cfg header
// Notes: selector codes are left to the tool
package ipr_pkg;

  typedef enum logic [3:0] {
    sel_none,
    sel_exception_return_address,
    sel_interrupt_request_clear,
    sel_serial_receive_line,
    sel_itlb_flush_all,
    sel_itlb_flush_nonglobal,
    sel_itlb_flush_single,
    sel_processor_mode_status,
    sel_arithmetic_trap_summary
  } ipr_sel_t;

  typedef enum logic [2:0] {
    exc_other,
    exc_privileged_call,
    exc_arith_trap,
    exc_machine_check,
    exc_reset
  } exc_kind_t;

endpackage

// ===== hw/sticky_flag.sv
// Purpose: one hardware-set, software-cleared status flag
// Assumes: set and clear synchronous to clk
// Notes: set wins so an event in the clearing cycle is kept
`timescale 1ns/10ps
`default_nettype none
module sticky_flag (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic set,
  input wire logic clr,
  // state
  output logic q
);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== dv/ipr_bank_tb.sv
// Purpose: self-checking bench for the exception and flush register group
// Assumes: inputs change on falling edges, one register move at a time
// Notes: reads spaced five cycles so a pending mask shift lands first
`timescale 1ns/10ps
`default_nettype none
`include "ipr_cfg.svh"
module exception_and_itlb_control_regs_tb_top
  import ipr_pkg::*;
;
  logic clk, arst_n, ipr_wr, ipr_rd, ipr_rd_valid;
  ipr_sel_t ipr_sel;
  logic [63:0] ipr_wdata, ipr_rdata, exc_pc, rei_target, got, d, pc, base;
  logic exc_valid, exc_in_privileged_mode, exc_pc_correct, b1;
  exc_kind_t exc_kind;
  logic return_from_exception, rei_jump, rei_privileged_code_mode;
  logic rei_translate_en, trap_valid, trap_sw_completion, trap_dest_float;
  logic [5:0] trap_flags, m_flags;
  logic [4:0] trap_dest_reg;
  logic icache_loaded, boot_rom_data_pin, serial_interrupt_enable;
  logic serial_interrupt_request, serial_irq, m_ok, m_swc;
  logic event_counter0_clear, event_counter1_clear;
  logic correctable_read_error_clear;
  logic itlb_invalidate_all, itlb_invalidate_nonglobal;
  logic [63:0] m_mask;
  int err_total, n_compared;
  ipr_sel_t wo[5] = '{sel_interrupt_request_clear, sel_itlb_flush_all,
    sel_itlb_flush_nonglobal, sel_itlb_flush_single, sel_none};

  ipr_bank #(.MASK_W(`MASK_W)) dut (
    .clk(clk), .arst_n(arst_n), .ipr_wr(ipr_wr), .ipr_rd(ipr_rd),
    .ipr_sel(ipr_sel), .ipr_wdata(ipr_wdata), .ipr_rdata(ipr_rdata),
    .ipr_rd_valid(ipr_rd_valid), .exc_valid(exc_valid),
    .exc_kind(exc_kind), .exc_pc(exc_pc),
    .exc_in_privileged_mode(exc_in_privileged_mode),
    .exc_pc_correct(exc_pc_correct),
    .return_from_exception(return_from_exception), .rei_jump(rei_jump),
    .rei_target(rei_target),
    .rei_privileged_code_mode(rei_privileged_code_mode),
    .rei_translate_en(rei_translate_en), .trap_valid(trap_valid),
    .trap_flags(trap_flags), .trap_sw_completion(trap_sw_completion),
    .trap_dest_float(trap_dest_float), .trap_dest_reg(trap_dest_reg),
    .icache_loaded(icache_loaded), .boot_rom_data_pin(boot_rom_data_pin),
    .serial_interrupt_enable(serial_interrupt_enable),
    .serial_interrupt_request(serial_interrupt_request),
    .serial_irq(serial_irq), .event_counter0_clear(event_counter0_clear),
    .event_counter1_clear(event_counter1_clear),
    .correctable_read_error_clear(correctable_read_error_clear),
    .itlb_invalidate_all(itlb_invalidate_all),
    .itlb_invalidate_nonglobal(itlb_invalidate_nonglobal)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input ipr_sel_t s, input logic [63:0] v);
    @(negedge clk);
    ipr_wr = 1'b1;
    ipr_sel = s;
    ipr_wdata = v;
    @(negedge clk);
    ipr_wr = 1'b0;
  endtask

  // pulse order: all, nonglobal, counter0, counter1, read error
  task automatic wr_pulse(input ipr_sel_t s, input logic [63:0] v,
                          input logic [4:0] exp);
    wr(s, v);
    chk("pulses", {59'h0, exp}, {59'h0, itlb_invalidate_all,
      itlb_invalidate_nonglobal, event_counter0_clear,
      event_counter1_clear, correctable_read_error_clear});
  endtask

  task automatic rd(input ipr_sel_t s, output logic [63:0] v);
    @(negedge clk);
    ipr_rd = 1'b1;
    ipr_sel = s;
    @(negedge clk);
    ipr_rd = 1'b0;
    chk("read valid", 64'h1, {63'h0, ipr_rd_valid});
    v = ipr_rdata;
    repeat (3) @(negedge clk);
  endtask

  function automatic logic [63:0] sum_exp();
    sum_exp = 64'h0;
    sum_exp[`SUM_MSK_BIT] = m_mask[63];
    sum_exp[`SUM_FLAG_LO_BIT +: `SUM_FLAG_W] = m_flags;
    sum_exp[`SUM_SWC_BIT] = m_swc;
  endfunction

  task automatic rd_sum();
    rd(sel_arithmetic_trap_summary, got);
    chk("summary", sum_exp(), got);
    m_mask = m_mask << 1;
  endtask

  task automatic trap(input logic [5:0] f, input logic q, input logic fl,
                      input logic [4:0] r);
    @(negedge clk);
    trap_valid = 1'b1;
    trap_flags = f;
    trap_sw_completion = q;
    trap_dest_float = fl;
    trap_dest_reg = r;
    @(negedge clk);
    trap_valid = 1'b0;
    m_flags = m_flags | f;
    m_ok = m_ok & q;
    m_swc = m_ok;
    m_mask[{fl, r}] = 1'b1;
  endtask

  task automatic sum_write();
    wr(sel_arithmetic_trap_summary, {$urandom, $urandom});
    m_flags = 6'h0;
    m_swc = 1'b0;
    m_ok = 1'b1;
  endtask

  initial begin
    #100000;
    err_total++;
    summarize();
  end

  initial begin
    {arst_n, ipr_wr, ipr_rd, exc_valid, exc_in_privileged_mode} = '0;
    {exc_pc_correct, return_from_exception, trap_valid} = '0;
    {trap_sw_completion, trap_dest_float, icache_loaded} = '0;
    {boot_rom_data_pin, serial_interrupt_enable} = '0;
    {ipr_wdata, exc_pc, trap_flags, trap_dest_reg} = '0;
    {m_mask, m_flags, m_swc} = '0;
    m_ok = 1'b1;
    ipr_sel = sel_none;
    exc_kind = exc_other;
    void'($urandom(32'hf3529388));
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    for (int k = 0; k < 10; k++) begin
      exc_kind_t kd;
      kd = exc_kind_t'(k % 5);
      pc = {$urandom, $urandom} & ~64'h3;
      @(negedge clk);
      exc_valid = 1'b1;
      exc_kind = kd;
      exc_pc = pc;
      exc_in_privileged_mode = 1'($urandom);
      exc_pc_correct = 1'($urandom);
      @(negedge clk);
      exc_valid = 1'b0;
      base = (kd == exc_privileged_call) ? pc + `PC_STEP : pc;
      b1 = (kd == exc_arith_trap || kd == exc_machine_check) ?
        exc_pc_correct : 1'b0;
      rd(sel_exception_return_address, got);
      chk("ret addr", {base[63:2], b1, exc_in_privileged_mode}, got);
    end
    for (int i = 0; i < 2; i++) begin
      d = {$urandom, $urandom};
      d[0] = i[0];
      wr(sel_exception_return_address, d);
      rd(sel_exception_return_address, got);
      chk("ret addr rw", d, got);
      @(negedge clk);
      return_from_exception = 1'b1;
      @(negedge clk);
      return_from_exception = 1'b0;
      chk("jump", 64'h1, {63'h0, rei_jump});
      chk("target", {d[63:2], 2'b00}, rei_target);
      chk("mode", {63'h0, d[0]}, {63'h0, rei_privileged_code_mode});
      chk("xlate", {63'h0, ~d[0]}, {63'h0, rei_translate_en});
      d = {$urandom, $urandom};
      wr(sel_processor_mode_status, d);
      rd(sel_processor_mode_status, got);
      chk("mode reg", d & (64'h3 << `MODE_LO_BIT), got);
    end
    foreach (wo[j]) begin
      rd(wo[j], got);
      chk("wo read", 64'h0, got);
    end
    // flush writes stand for moves made in privileged mode only
    wr_pulse(sel_itlb_flush_all, {$urandom, $urandom}, 5'h10);
    wr_pulse(sel_itlb_flush_single, {$urandom, $urandom}, 5'h10);
    wr_pulse(sel_itlb_flush_nonglobal, {$urandom, $urandom}, 5'h08);
    d = ~64'h0;
    wr_pulse(sel_interrupt_request_clear, d ^ (64'h1 << 3), 5'h01);
    wr_pulse(sel_interrupt_request_clear, d ^ (64'h1 << 8), 5'h04);
    wr_pulse(sel_interrupt_request_clear, d ^ (64'h1 << 15), 5'h02);
    d = {$urandom, $urandom} | 64'h1_0000_8108;
    wr_pulse(sel_interrupt_request_clear, d, 5'h00);
    icache_loaded = 1'b1;
    for (int i = 0; i < 2; i++) begin
      serial_interrupt_enable = 1'b0;
      boot_rom_data_pin = ~boot_rom_data_pin;
      repeat (3) @(negedge clk);
      chk("serial_interrupt_request", 64'h1, {63'h0, serial_interrupt_request});
      chk("sl irq off", 64'h0, {63'h0, serial_irq});
      rd(sel_serial_receive_line, got);
      chk("rcv", {63'h0, boot_rom_data_pin}, got);
      serial_interrupt_enable = 1'b1;
      repeat (3) @(negedge clk);
      chk("sl irq on", 64'h1, {63'h0, serial_irq});
      wr(sel_interrupt_request_clear, ~(64'h1 << `CLR_SLC_BIT));
      repeat (3) @(negedge clk);
      chk("sl cleared", 64'h0, {63'h0, serial_interrupt_request});
    end
    sum_write();
    trap(6'($urandom), 1'b1, 1'b1, 5'd31);
    trap(6'($urandom), 1'b1, 1'b1, 5'd30);
    rd_sum();
    // two reads back to back: the second sees the same, set, bit
    @(negedge clk);
    ipr_rd = 1'b1;
    ipr_sel = sel_arithmetic_trap_summary;
    @(negedge clk);
    chk("sum b2b 0", sum_exp(), ipr_rdata);
    @(negedge clk);
    ipr_rd = 1'b0;
    chk("sum b2b 1", sum_exp(), ipr_rdata);
    @(negedge clk);
    chk("sum b2b 2", sum_exp(), ipr_rdata);
    m_mask = m_mask << 1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      trap(6'($urandom), 1'($urandom), 1'($urandom), 5'($urandom));
    end
    trap(6'h01, 1'b0, 1'b0, 5'd0);
    rd_sum();
    sum_write();
    for (int i = 0; i < 64; i++) begin
      rd_sum();
    end
    @(negedge clk);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    rd(sel_exception_return_address, got);
    chk("rst addr", 64'h0, got);
    rd(sel_processor_mode_status, got);
    chk("rst mode", 64'h0, got);
    summarize();
  end
endmodule
`default_nettype wire
